/* File: shared/eeprom_pins_pkg.sv */
/*
 Shared constants for the serial EEPROM pin block: word widths, variant codes, output states.
 Assumes the system clock runs at 250 MHz and host pins are synchronous to it.
*/
package eeprom_pins_pkg;
   localparam int CLK_PERIOD_PS = 4000;
   // Least chip-select-low time in ns
   localparam int SELECT_LOW_MIN_TIME_NS = 250;
   localparam int SELECT_LOW_MIN_CYC =
      (SELECT_LOW_MIN_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CSL_CNT_W = 7;
   localparam int WIDE_WORD = 16;
   localparam int NARROW_WORD = 8;
   localparam int BIT_CNT_W = 5;
   // Variant codes
   localparam logic [1:0] VAR_FIXED_NARROW = 2'h0;
   localparam logic [1:0] VAR_FIXED_WIDE = 2'h1;
   localparam logic [1:0] VAR_SELECTABLE = 2'h2;
   // Default self-timed program cycle length in clocks
   localparam int PROG_CYCLES_DEF = 1250000;
   localparam int PROG_CNT_W = 24;

   typedef enum logic [3:0] {
      OUT_IDLE   = 4'h1,
      OUT_DUMMY  = 4'h2,
      OUT_DATA   = 4'h4,
      OUT_STATUS = 4'h8
   } out_state_e;
endpackage

/* File: rtl/prog_timer.sv */
/*
 Self-timed programming cycle timer.
 Assumes start is a one-cycle strobe; a start while busy is ignored.
*/
`timescale 1ns/100ps
module prog_timer #(
   parameter int CNT_W = 24
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [CNT_W-1:0] length,
   output logic busy
);
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic busy_ff;
   logic nxt_busy;

   assign nxt_busy = busy_ff ? (cnt_ff > {{(CNT_W-1){1'b0}}, 1'b1}) : start;
   assign nxt_cnt = busy_ff ? cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1} : (start ? length : cnt_ff);
   assign busy = busy_ff;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
         busy_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         busy_ff <= nxt_busy;
      end
   end
endmodule

/* File: rtl/eeprom_pins.sv */
/*
 Data-out, organization and program-permit logic of a three-wire serial EEPROM.
 Assumes the instruction decoder upstream supplies read start, read words,
 program requests, lock/unlock and start-bit strobes, all synchronous to clock.
*/
`timescale 1ns/100ps
module eeprom_pins #(
   parameter logic [1:0] VARIANT = eeprom_pins_pkg::VAR_SELECTABLE,
   parameter int PROG_CYCLES = eeprom_pins_pkg::PROG_CYCLES_DEF
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic chip_select,
   input wire logic serial_clock,
   input wire logic start_bit_seen,
   input wire logic read_start,
   input wire logic [eeprom_pins_pkg::WIDE_WORD-1:0] read_word,
   input wire logic prog_request,
   input wire logic programming_unlock_instruction,
   input wire logic programming_lock_instruction,
   input wire logic word_width_select,
   input wire logic program_permit_input,
   output logic data_out,
   output logic data_out_oe,
   output logic wide_words,
   output logic prog_start,
   output logic prog_busy,
   output logic read_word_taken
);
   import eeprom_pins_pkg::*;

   // -------------------------------------------------------------
   // Reset release
   // -------------------------------------------------------------
   logic rst_meta_ff;
   logic rst_ff;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_ff <= 1'b0;
         rst_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_ff <= rst_meta_ff;
      end
   end

   // -------------------------------------------------------------
   // Organization and permit
   // -------------------------------------------------------------
   logic wide_sel;
   logic permit;
   assign wide_sel = (VARIANT == VAR_SELECTABLE) ? word_width_select
                   : (VARIANT == VAR_FIXED_WIDE);
   assign permit = (VARIANT == VAR_SELECTABLE) ? program_permit_input
                 : 1'b1;

   // -------------------------------------------------------------
   // Serial clock edge and select-low timing
   // -------------------------------------------------------------
   logic sclk_d_ff;
   logic cs_d_ff;
   logic sclk_rise;
   logic cs_rise;
   logic cs_fall;
   logic [CSL_CNT_W-1:0] csl_cnt_ff;
   logic [CSL_CNT_W-1:0] nxt_csl_cnt;
   logic csl_ok;
   localparam logic [CSL_CNT_W-1:0] CSL_MIN = CSL_CNT_W'(SELECT_LOW_MIN_CYC);
   assign sclk_rise = serial_clock && !sclk_d_ff;
   assign cs_rise = chip_select && !cs_d_ff;
   assign cs_fall = !chip_select && cs_d_ff;
   assign csl_ok = (csl_cnt_ff >= CSL_MIN);
   assign nxt_csl_cnt = chip_select ? '0 : (csl_ok ? csl_cnt_ff : csl_cnt_ff + 1'b1);

   // -------------------------------------------------------------
   // Write enable latch and programming cycle
   // -------------------------------------------------------------
   logic unlocked_ff;
   logic nxt_unlocked;
   logic nxt_prog_start;
   logic timer_busy;
   logic [PROG_CNT_W-1:0] prog_len;
   assign prog_len = PROG_CNT_W'(PROG_CYCLES);
   assign nxt_unlocked = programming_lock_instruction ? 1'b0
                       : (programming_unlock_instruction ? 1'b1 : unlocked_ff);
   // Request only counts while selected; timer runs regardless of select
   assign nxt_prog_start = prog_request && chip_select && unlocked_ff && permit
                         && !timer_busy;

   prog_timer #(.CNT_W(PROG_CNT_W)) u_timer (
      .clock(clock),
      .rst_n(rst_ff),
      .start(prog_start),
      .length(prog_len),
      .busy(timer_busy)
   );

   // -------------------------------------------------------------
   // Status pending flag
   // -------------------------------------------------------------
   logic pend_ff;
   logic nxt_pend;
   logic status_clear;
   // Status cleared by a start bit followed by select low while the timer is not busy
   logic start_seen_ff;
   logic nxt_start_seen;
   assign nxt_start_seen = chip_select && (start_bit_seen || (start_seen_ff && !cs_fall));
   assign status_clear = cs_fall && start_seen_ff && !timer_busy;
   assign nxt_pend = prog_start ? 1'b1 : (status_clear ? 1'b0 : pend_ff);

   // -------------------------------------------------------------
   // Output state machine
   // -------------------------------------------------------------
   out_state_e state_ff;
   out_state_e nxt_state;
   logic [WIDE_WORD-1:0] shift_ff;
   logic [WIDE_WORD-1:0] nxt_shift;
   logic [BIT_CNT_W-1:0] bits_ff;
   logic [BIT_CNT_W-1:0] nxt_bits;
   logic [BIT_CNT_W-1:0] word_len;
   logic nxt_do;
   logic nxt_oe;
   logic nxt_taken;
   logic status_show;
   assign word_len = wide_sel ? BIT_CNT_W'(WIDE_WORD) : BIT_CNT_W'(NARROW_WORD);
   // Status shows once select rises after a valid low time
   assign status_show = cs_rise && csl_ok && (pend_ff || prog_start);

   always_comb begin
      nxt_state = state_ff;
      nxt_shift = shift_ff;
      nxt_bits = bits_ff;
      nxt_taken = 1'b0;
      case (state_ff)
         OUT_IDLE: begin
            if (status_show) begin
               nxt_state = OUT_STATUS;
            end else if (read_start && chip_select) begin
               nxt_state = OUT_DUMMY;
            end
         end
         OUT_DUMMY: begin
            if (sclk_rise) begin
               nxt_state = OUT_DATA;
               nxt_shift = wide_sel ? read_word : {read_word[NARROW_WORD-1:0], 8'h00};
               nxt_bits = word_len;
               nxt_taken = 1'b1;
            end
         end
         OUT_DATA: begin
            if (sclk_rise) begin
               if (bits_ff == 5'h01) begin
                  // Sequential read: next word follows directly
                  nxt_shift = wide_sel ? read_word : {read_word[NARROW_WORD-1:0], 8'h00};
                  nxt_bits = word_len;
                  nxt_taken = 1'b1;
               end else begin
                  nxt_shift = {shift_ff[WIDE_WORD-2:0], 1'b0};
                  nxt_bits = bits_ff - 5'h01;
               end
            end
         end
         OUT_STATUS: begin
            if (status_clear) begin
               nxt_state = OUT_IDLE;
            end
         end
         default: nxt_state = OUT_IDLE;
      endcase
      if (!chip_select && (state_ff != OUT_STATUS)) begin
         nxt_state = OUT_IDLE;
      end
   end

   assign nxt_oe = (nxt_state != OUT_IDLE);
   assign nxt_do = (nxt_state == OUT_STATUS) ? !timer_busy
                 : (nxt_state == OUT_DATA) ? nxt_shift[WIDE_WORD-1] : 1'b0;

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_ff) begin
      if (!rst_ff) begin
         sclk_d_ff <= 1'b0;
         cs_d_ff <= 1'b0;
         csl_cnt_ff <= '0;
         unlocked_ff <= 1'b0;
         prog_start <= 1'b0;
         pend_ff <= 1'b0;
         start_seen_ff <= 1'b0;
         state_ff <= OUT_IDLE;
         shift_ff <= '0;
         bits_ff <= '0;
         data_out <= 1'b0;
         data_out_oe <= 1'b0;
         wide_words <= 1'b0;
         prog_busy <= 1'b0;
         read_word_taken <= 1'b0;
      end else begin
         sclk_d_ff <= serial_clock;
         cs_d_ff <= chip_select;
         csl_cnt_ff <= nxt_csl_cnt;
         unlocked_ff <= nxt_unlocked;
         prog_start <= nxt_prog_start;
         pend_ff <= nxt_pend;
         start_seen_ff <= nxt_start_seen;
         state_ff <= nxt_state;
         shift_ff <= nxt_shift;
         bits_ff <= nxt_bits;
         data_out <= nxt_do;
         data_out_oe <= nxt_oe;
         wide_words <= wide_sel;
         prog_busy <= timer_busy;
         read_word_taken <= nxt_taken;
      end
   end
endmodule

/* File: tb/eeprom_pins_monitor.sv */
/*
 Port checker for eeprom_pins.
 Assumes it is bound to every eeprom_pins instance, one clock domain.
*/
`timescale 1ns/100ps
module eeprom_pins_monitor #(
   parameter logic [1:0] VARIANT = eeprom_pins_pkg::VAR_SELECTABLE,
   parameter int PROG_CYCLES = eeprom_pins_pkg::PROG_CYCLES_DEF
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic chip_select,
   input wire logic serial_clock,
   input wire logic start_bit_seen,
   input wire logic read_start,
   input wire logic prog_request,
   input wire logic program_permit_input,
   input wire logic data_out,
   input wire logic data_out_oe,
   input wire logic prog_start,
   input wire logic prog_busy,
   input wire logic read_word_taken
);
   int busy_len_ff;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         busy_len_ff <= 0;
      else
         busy_len_ff <= prog_busy ? busy_len_ff + 1 : 0;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   prog_gate_a:
      assert property (prog_start |-> $past(prog_request && chip_select
         && (program_permit_input || (VARIANT != eeprom_pins_pkg::VAR_SELECTABLE))))
      else $error("start without permitted request");
   busy_follows_a:
      assert property (prog_start |-> ##2 prog_busy) else $error("busy missing after start");
   busy_length_a:
      assert property ($fell(prog_busy) |-> busy_len_ff == PROG_CYCLES)
      else $error("wrong busy length");
   status_low_a:
      assert property (prog_busy && $past(prog_busy) && data_out_oe |-> !data_out)
      else $error("status high while busy");
   dummy_first_a:
      assert property (read_start && chip_select && !data_out_oe |=> data_out_oe && !data_out)
      else $error("dummy zero missing");
   shift_edge_a:
      assert property (read_word_taken |-> $past(serial_clock) && !$past(serial_clock, 2))
      else $error("load not on clock rise");
   status_clear_a:
      assert property (start_bit_seen && chip_select && !prog_busy ##[1:2] !chip_select
         |-> ##[1:3] !data_out_oe) else $error("status not cleared");
   oe_cause_a:
      assert property ($rose(data_out_oe) |-> $past(chip_select)
         && ($past(read_start) || !$past(chip_select, 2)))
      else $error("output driven without cause");
endmodule
bind eeprom_pins eeprom_pins_monitor #(.VARIANT(VARIANT), .PROG_CYCLES(PROG_CYCLES))
   u_eeprom_pins_monitor (
   .clock(clock), .reset_n(reset_n), .chip_select(chip_select),
   .serial_clock(serial_clock), .start_bit_seen(start_bit_seen), .read_start(read_start),
   .prog_request(prog_request), .program_permit_input(program_permit_input),
   .data_out(data_out), .data_out_oe(data_out_oe), .prog_start(prog_start),
   .prog_busy(prog_busy), .read_word_taken(read_word_taken));

/* File: tb/host_model.sv */
/*
 Host controller driving select and serial clock.
 Assumes the caller steps it from the system clock's falling edge.
*/
`timescale 1ns/100ps
module host_model (
   input wire logic clock,
   output logic chip_select,
   output logic serial_clock
);
   import eeprom_pins_pkg::*;
   // Serial clock stands low outside frames
   initial begin
      chip_select = 1'b0;
      serial_clock = 1'b0;
   end
   task automatic drop;
      @(negedge clock) chip_select = 1'b0;
   endtask
   task automatic gap;
      drop();
      repeat (SELECT_LOW_MIN_CYC + 2) @(negedge clock);
      chip_select = 1'b1;
   endtask
   task automatic rise;
      @(negedge clock) serial_clock = 1'b1;
      repeat (3) @(negedge clock);
      serial_clock = 1'b0;
   endtask
endmodule

/* File: tb/tb.sv */
/*
 Testbench for eeprom_pins with a host model.
 Assumes a shortened programming cycle of 200 clocks.
*/
`timescale 1ns/100ps
module tb;
   import eeprom_pins_pkg::*;
   logic clock = 0, reset_n = 0, start_bit_seen = 0, read_start = 0, prog_request = 0;
   logic unlock = 0, lock = 0, width_sel = 0, permit = 0;
   logic [15:0] word = 16'ha5c3;
   logic chip_select, serial_clock, data_out, data_out_oe, prog_busy;
   logic wide_words, fixed_wide, fixed_busy;
   int err_total = 0, checks_done = 0;
   always #2 clock = ~clock;
   eeprom_pins #(.PROG_CYCLES(200)) u_eeprom_pins (.clock(clock), .reset_n(reset_n),
      .chip_select(chip_select), .serial_clock(serial_clock), .start_bit_seen(start_bit_seen),
      .read_start(read_start), .read_word(word), .prog_request(prog_request),
      .programming_unlock_instruction(unlock), .programming_lock_instruction(lock),
      .word_width_select(width_sel), .program_permit_input(permit), .data_out(data_out),
      .data_out_oe(data_out_oe), .wide_words(wide_words), .prog_start(), .prog_busy(prog_busy),
      .read_word_taken());
   host_model u_host_model (.clock(clock), .chip_select(chip_select),
      .serial_clock(serial_clock));
   // Fixed-width variant without permit pin, sharing all stimulus
   eeprom_pins #(.VARIANT(VAR_FIXED_WIDE), .PROG_CYCLES(200)) u_eeprom_pins_fixed (
      .clock(clock), .reset_n(reset_n), .chip_select(chip_select),
      .serial_clock(serial_clock), .start_bit_seen(start_bit_seen), .read_start(read_start),
      .read_word(word), .prog_request(prog_request),
      .programming_unlock_instruction(unlock), .programming_lock_instruction(lock),
      .word_width_select(width_sel), .program_permit_input(permit), .data_out(),
      .data_out_oe(), .wide_words(fixed_wide), .prog_start(), .prog_busy(fixed_busy),
      .read_word_taken());
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic strobe(ref logic s);
      @(negedge clock) s = 1'b1;
      @(negedge clock) s = 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      while (prog_busy !== 1'b0 && n < 1000) begin
         @(negedge clock);
         n++;
      end
      cmp(prog_busy, 1'b0);
   endtask
   task automatic stop_test;
      $display("errors=%0d checks=%0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      stop_test();
   end
   initial begin
      settle(5);
      reset_n = 1'b1;
      settle(3);
      cmp(data_out_oe, 1'b0);
      u_host_model.gap();
      permit = 1'b1;
      strobe(prog_request);
      settle(3);
      cmp(prog_busy, 1'b0);
      strobe(unlock);
      permit = 1'b0;
      strobe(prog_request);
      settle(3);
      cmp(prog_busy, 1'b0);
      cmp(fixed_busy, 1'b1);
      permit = 1'b1;
      strobe(prog_request);
      settle(3);
      cmp(prog_busy, 1'b1);
      u_host_model.gap();
      settle(2);
      cmp({data_out_oe, data_out}, 2'b10);
      wait_idle();
      settle(2);
      cmp({data_out_oe, data_out}, 2'b11);
      strobe(start_bit_seen);
      u_host_model.drop();
      settle(3);
      cmp(data_out_oe, 1'b0);
      u_host_model.gap();
      strobe(prog_request);
      u_host_model.drop();
      settle(3);
      cmp(prog_busy, 1'b1);
      wait_idle();
      settle(2);
      cmp(data_out_oe, 1'b0);
      u_host_model.gap();
      settle(2);
      cmp({data_out_oe, data_out}, 2'b11);
      strobe(start_bit_seen);
      u_host_model.gap();
      strobe(lock);
      strobe(prog_request);
      settle(3);
      cmp(prog_busy, 1'b0);
      cmp(fixed_busy, 1'b0);
      for (int w = 1; w >= 0; w--) begin
         width_sel = w[0];
         strobe(read_start);
         settle(1);
         cmp({data_out_oe, data_out}, 2'b10);
         cmp(wide_words, w[0]);
         cmp(fixed_wide, 1'b1);
         // Two words back to back: the second one loads by itself
         for (int i = 0; i < 16 + 16 * w; i++) begin
            u_host_model.rise();
            cmp(data_out, word[7 + 8 * w - i % (8 + 8 * w)]);
         end
         u_host_model.drop();
         settle(2);
         cmp(data_out_oe, 1'b0);
         u_host_model.gap();
      end
      stop_test();
   end
endmodule
